// *** src/sli_consts.svh ***
/*
  Constants of the status indicator block: register offsets, field positions,
  reset values and display timing.
  Assumes a 200 MHz system clock and a 10 ms display tick.
*/
`ifndef SLI_CONSTS_SVH
`define SLI_CONSTS_SVH

// ----------------------------------------------------------------
// clock and tick
// ----------------------------------------------------------------
`define SLI_CLK_MHZ        200
`define SLI_TICK_MS        10
`define SLI_TICK_CYC       (`SLI_TICK_MS * 1000 * `SLI_CLK_MHZ)

// ----------------------------------------------------------------
// display times in ms, and in ticks
// ----------------------------------------------------------------
`define SLI_NS_PULSE_MS    1000
`define SLI_AB_ON_MS       200
`define SLI_AB_OFF_MS      300
`define SLI_AB_GAP_MS      1500
`define SLI_SIM_STEP_MS    500
`define SLI_ACT_HOLD_MS    100
`define SLI_NS_PULSE_TK    8'(`SLI_NS_PULSE_MS / `SLI_TICK_MS)
`define SLI_AB_ON_TK       8'(`SLI_AB_ON_MS / `SLI_TICK_MS)
`define SLI_AB_OFF_TK      8'(`SLI_AB_OFF_MS / `SLI_TICK_MS)
`define SLI_AB_GAP_TK      8'(`SLI_AB_GAP_MS / `SLI_TICK_MS)
`define SLI_SIM_STEP_TK    8'(`SLI_SIM_STEP_MS / `SLI_TICK_MS)
`define SLI_ACT_HOLD_TK    8'(`SLI_ACT_HOLD_MS / `SLI_TICK_MS)

// blink phases taken from bits of a free-running tick counter
`define SLI_BLINK_BIT      4
`define SLI_ACT_BIT        2

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
`define SLI_CTRL_OFF       12'h000
`define SLI_STAT_OFF       12'h004
`define SLI_CTRL_RST       3'h0
`define SLI_CTRL_SIM       0
`define SLI_CTRL_REMOTE    1
`define SLI_CTRL_ARST      2

`endif

// *** src/sli_pkg.sv ***
/*
  Types of the status indicator block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sli_pkg;

  typedef enum logic [3:0] {
    PM_NORM  = 4'b0001,
    PM_SIM   = 4'b0010,
    PM_ALARM = 4'b0100,
    PM_INFO  = 4'b1000
  } sli_pa_mode_e;

  typedef enum logic [2:0] {
    AB_ON  = 3'b001,
    AB_OFF = 3'b010,
    AB_GAP = 3'b100
  } sli_ab_state_e;

endpackage

// *** src/sli_tick_div.sv ***
/*
  Divider giving a one-cycle display tick every TICK_CYC clocks.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module sli_tick_div import sli_pkg::*; #(
  parameter int unsigned TICK_CYC = 2000000
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // tick
  output logic      tick_o
);

  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        next_tick;

  always_comb begin
    next_tick = 1'b0;
    next_cnt  = cnt + 32'h1;
    if (cnt >= 32'(TICK_CYC - 1)) begin
      next_cnt  = 32'h0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt    <= 32'h0;
      tick_o <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      tick_o <= next_tick;
    end
  end

  // ticks never come back to back unless the divide is one
  AST_TICK_SPACING: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (tick_o && TICK_CYC > 1) |=> !tick_o)
    else $error("display ticks back to back");

endmodule
`default_nettype wire

// *** src/sli_pulse_timer.sv ***
/*
  Retriggerable pulse stretcher counting display ticks.
  Assumes trig_i and tick_i are on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module sli_pulse_timer import sli_pkg::*; (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // control
  input  wire logic       tick_i,
  input  wire logic       trig_i,
  input  wire logic [7:0] len_i,
  // state
  output logic            active_o
);

  logic [7:0] cnt;
  logic [7:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (trig_i) begin
      next_cnt = len_i;
    end else if (tick_i && cnt != 8'h0) begin
      next_cnt = cnt - 8'h1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= 8'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign active_o = (cnt != 8'h0);

  AST_PULSE_RETRIG: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    trig_i |=> (cnt == $past(len_i)))
    else $error("pulse not reloaded on trigger");

endmodule
`default_nettype wire

// *** src/sli_status_led.sv ***
/*
  Front-panel status indicator logic: power/alarm, module state,
  network state and link/activity, with an APB register slave.
  Assumes all event inputs come from logic on clk_i, one clock.
*/
`include "sli_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module sli_status_led import sli_pkg::*; #(
  parameter int unsigned TICK_CYC = `SLI_TICK_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // status events
  input  wire logic        alarm_i,
  input  wire logic [3:0]  alarm_code_i,
  input  wire logic        info_i,
  input  wire logic        cfg_corrupt_i,
  input  wire logic        internal_err_i,
  input  wire logic        tcp_conn_evt_i,
  input  wire logic        frame_ok_i,
  input  wire logic        frame_err_i,
  input  wire logic        link_up_i,
  input  wire logic        eth_traffic_i,
  // indicators
  output logic             pa_green_o,
  output logic             pa_red_o,
  output logic             pa_blue_o,
  output logic             ms_green_o,
  output logic             ms_red_o,
  output logic             ns_green_o,
  output logic             ns_red_o,
  output logic             link_act_o
);

  // ----------------------------------------------------------------
  // tick and stretchers
  // ----------------------------------------------------------------
  logic tick;
  logic ns_green_act;
  logic ns_red_act;
  logic traffic_act;

  sli_tick_div #(.TICK_CYC(TICK_CYC)) u_tick (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .tick_o   (tick)
  );

  sli_pulse_timer u_ns_green (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .tick_i   (tick),
    .trig_i   (tcp_conn_evt_i | frame_ok_i),
    .len_i    (`SLI_NS_PULSE_TK),
    .active_o (ns_green_act)
  );

  sli_pulse_timer u_ns_red (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .tick_i   (tick),
    .trig_i   (frame_err_i),
    .len_i    (`SLI_NS_PULSE_TK),
    .active_o (ns_red_act)
  );

  // traffic seen recently counts as activity
  sli_pulse_timer u_traffic (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .tick_i   (tick),
    .trig_i   (eth_traffic_i & link_up_i),
    .len_i    (`SLI_ACT_HOLD_TK),
    .active_o (traffic_act)
  );

  // ----------------------------------------------------------------
  // registers and latched conditions
  // ----------------------------------------------------------------
  logic [2:0]  ctrl;
  logic        alarm_act;
  logic [3:0]  alarm_code;
  logic        int_err;
  logic        wr_ack;
  logic        rd_ack;
  logic        arst_pulse;
  logic [2:0]  next_ctrl;
  logic        next_alarm_act;
  logic [3:0]  next_alarm_code;
  logic        next_int_err;
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] next_prdata;
  logic        addr_ok;

  assign wr_ack     = psel_i & penable_i & pready_o & pwrite_i;
  assign rd_ack     = psel_i & penable_i & ~pready_o & ~pwrite_i;
  assign addr_ok    = (paddr_i == `SLI_CTRL_OFF) | (paddr_i == `SLI_STAT_OFF);
  assign arst_pulse = wr_ack & (paddr_i == `SLI_CTRL_OFF) & pwdata_i[`SLI_CTRL_ARST];

  always_comb begin
    next_ctrl       = ctrl;
    next_alarm_act  = alarm_act;
    next_alarm_code = alarm_code;
    next_int_err    = int_err | internal_err_i;
    next_pready     = psel_i & penable_i & ~pready_o;
    next_pslverr    = psel_i & penable_i & ~pready_o & ~addr_ok;
    next_prdata     = 32'h0;
    if (wr_ack && paddr_i == `SLI_CTRL_OFF) begin
      next_ctrl                = pwdata_i[2:0];
      next_ctrl[`SLI_CTRL_ARST] = 1'b0;
    end
    if (arst_pulse) begin
      next_alarm_act = 1'b0;
    end
    // a new alarm in the clearing cycle wins
    if (alarm_i) begin
      next_alarm_act  = 1'b1;
      next_alarm_code = alarm_code_i;
    end
    if (rd_ack && paddr_i == `SLI_CTRL_OFF) begin
      next_prdata = {29'h0, ctrl};
    end else if (rd_ack && paddr_i == `SLI_STAT_OFF) begin
      next_prdata = {18'h0, link_act_o, ns_red_o, ns_green_o, ms_red_o, ms_green_o,
                     pa_blue_o, pa_red_o, pa_green_o, int_err, alarm_act, alarm_code};
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl       <= `SLI_CTRL_RST;
      alarm_act  <= 1'b0;
      alarm_code <= 4'h0;
      int_err    <= 1'b0;
      pready_o   <= 1'b0;
      pslverr_o  <= 1'b0;
      prdata_o   <= 32'h0;
    end else begin
      ctrl       <= next_ctrl;
      alarm_act  <= next_alarm_act;
      alarm_code <= next_alarm_code;
      int_err    <= next_int_err;
      pready_o   <= next_pready;
      pslverr_o  <= next_pslverr;
      prdata_o   <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // power/alarm mode and blink sequencer
  // ----------------------------------------------------------------
  sli_pa_mode_e  pa_mode;
  sli_pa_mode_e  next_pa_mode;
  sli_ab_state_e ab_state;
  sli_ab_state_e next_ab_state;
  logic [7:0]    phase_cnt;
  logic [7:0]    next_phase_cnt;
  logic [3:0]    blink_n;
  logic [3:0]    next_blink_n;
  logic [1:0]    sim_step;
  logic [1:0]    next_sim_step;
  logic [3:0]    blinks;
  logic [7:0]    phase_len;

  // code zero still gives one countable blink
  assign blinks = (alarm_code == 4'h0) ? 4'h1 : alarm_code;

  always_comb begin
    if (ctrl[`SLI_CTRL_SIM]) begin
      next_pa_mode = PM_SIM;
    end else if (alarm_act) begin
      next_pa_mode = PM_ALARM;
    end else if (info_i || ctrl[`SLI_CTRL_REMOTE]) begin
      next_pa_mode = PM_INFO;
    end else begin
      next_pa_mode = PM_NORM;
    end
  end

  always_comb begin
    unique case (ab_state)
      AB_ON:   phase_len = `SLI_AB_ON_TK;
      AB_OFF:  phase_len = `SLI_AB_OFF_TK;
      AB_GAP:  phase_len = `SLI_AB_GAP_TK;
      default: phase_len = `SLI_AB_ON_TK;
    endcase
    if (pa_mode == PM_SIM) begin
      phase_len = `SLI_SIM_STEP_TK;
    end
  end

  always_comb begin
    next_ab_state  = ab_state;
    next_phase_cnt = phase_cnt;
    next_blink_n   = blink_n;
    next_sim_step  = sim_step;
    if (next_pa_mode != pa_mode) begin
      // the alarm and simulation patterns restart from their first phase; the info blink runs on slow_cnt
      next_ab_state  = AB_ON;
      next_phase_cnt = 8'h0;
      next_blink_n   = 4'h0;
      next_sim_step  = 2'h0;
    end else if (tick && (pa_mode == PM_SIM || pa_mode == PM_ALARM)) begin
      next_phase_cnt = phase_cnt + 8'h1;
      if (phase_cnt >= phase_len - 8'h1) begin
        next_phase_cnt = 8'h0;
        if (pa_mode == PM_SIM) begin
          next_sim_step = sim_step + 2'h1;
        end else begin
          unique case (ab_state)
            AB_ON: begin
              next_ab_state = AB_OFF;
            end
            AB_OFF: begin
              if (blink_n + 4'h1 >= blinks) begin
                next_ab_state = AB_GAP;
                next_blink_n  = 4'h0;
              end else begin
                next_ab_state = AB_ON;
                next_blink_n  = blink_n + 4'h1;
              end
            end
            AB_GAP: begin
              next_ab_state = AB_ON;
            end
            default: begin
              next_ab_state = AB_ON;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pa_mode   <= PM_NORM;
      ab_state  <= AB_ON;
      phase_cnt <= 8'h0;
      blink_n   <= 4'h0;
      sim_step  <= 2'h0;
    end else begin
      pa_mode   <= next_pa_mode;
      ab_state  <= next_ab_state;
      phase_cnt <= next_phase_cnt;
      blink_n   <= next_blink_n;
      sim_step  <= next_sim_step;
    end
  end

  // ----------------------------------------------------------------
  // indicator outputs
  // ----------------------------------------------------------------
  logic [7:0] slow_cnt;
  logic [7:0] next_slow_cnt;
  logic [7:0] next_led;

  always_comb begin
    next_slow_cnt = tick ? slow_cnt + 8'h1 : slow_cnt;
    next_led      = 8'h0;
    // {pa_g, pa_r, pa_b, ms_g, ms_r, ns_g, ns_r, la}
    unique case (pa_mode)
      PM_NORM:  next_led[7] = 1'b1;
      PM_ALARM: next_led[6] = (ab_state == AB_ON);
      PM_INFO:  next_led[5] = slow_cnt[`SLI_BLINK_BIT];
      PM_SIM: begin
        next_led[7] = sim_step == 2'h0 || sim_step == 2'h2;
        next_led[6] = sim_step == 2'h1 || sim_step == 2'h2;
      end
      default: next_led[7] = 1'b1;
    endcase
    if (int_err) begin
      next_led[3] = 1'b1;
    end else if (cfg_corrupt_i) begin
      next_led[3] = slow_cnt[`SLI_BLINK_BIT];
    end else begin
      next_led[4] = 1'b1;
    end
    next_led[1] = ns_red_act;
    next_led[2] = ns_green_act & ~ns_red_act;
    if (link_up_i) begin
      next_led[0] = traffic_act ? slow_cnt[`SLI_ACT_BIT] : 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slow_cnt <= 8'h0;
      {pa_green_o, pa_red_o, pa_blue_o, ms_green_o, ms_red_o, ns_green_o, ns_red_o, link_act_o} <= 8'h0;
    end else begin
      slow_cnt <= next_slow_cnt;
      {pa_green_o, pa_red_o, pa_blue_o, ms_green_o, ms_red_o, ns_green_o, ns_red_o, link_act_o} <= next_led;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_err_seen;
    internal_err_i ##1 int_err;
  endsequence

  // the release edge itself still loads reset values into the outputs
  AST_NORMAL_GREEN: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (arst_n_i && pa_mode == PM_NORM) |=> pa_green_o && !pa_red_o && !pa_blue_o)
    else $error("normal mode not steady green");

  AST_ALARM_RED_ONLY: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    pa_mode == PM_ALARM |=> !pa_green_o && !pa_blue_o)
    else $error("alarm shows a colour other than red");

  AST_ALARM_CLEAR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (arst_pulse && !alarm_i && !ctrl[`SLI_CTRL_SIM]) |=> !alarm_act ##1 pa_mode != PM_ALARM)
    else $error("alarm not cleared by reset write");

  AST_INFO_BLUE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    pa_mode == PM_INFO |=> !pa_green_o && !pa_red_o)
    else $error("info mode shows green or red");

  AST_PRIORITY: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ctrl[`SLI_CTRL_SIM] |=> pa_mode == PM_SIM)
    else $error("simulation did not take priority");

  AST_SIM_BOTH: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (pa_mode == PM_SIM && next_pa_mode == PM_SIM && sim_step == 2'h2) |=> pa_green_o && pa_red_o)
    else $error("simulation third step not both colours");

  AST_ALARM_GAP_DARK: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (pa_mode == PM_ALARM && ab_state != AB_ON) |=> !pa_red_o)
    else $error("red lit outside blink on phase");

  AST_INTERR_HOLD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_err_seen |=> (int_err && ms_red_o && !ms_green_o) [*4])
    else $error("internal error not held steady red");

  AST_NS_RED_WINS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ns_red_act |=> ns_red_o && !ns_green_o)
    else $error("network red not taking precedence");

  AST_LINK_DARK: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !link_up_i |=> !link_act_o)
    else $error("link indicator lit while offline");

endmodule
`default_nettype wire

// *** tb/sli_led_watch.sv ***
/*
  Operator model: watches the power/alarm indicator and counts red and blue
  blinks, and keeps the last four green/red colour changes.
  Assumes indicator outputs registered on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module sli_led_watch (
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  arst_n_i,
  // indicators seen by the operator
  input  wire logic  pa_green_i,
  input  wire logic  pa_red_i,
  input  wire logic  pa_blue_i,
  // what the operator has counted
  output var int     red_rises_o,
  output var int     blue_rises_o,
  output logic [7:0] hist_o
);
  // ----------------------------------------------------------------
  // edge counting
  // ----------------------------------------------------------------
  logic [2:0] prev;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev <= 3'h0;
      red_rises_o <= 0;
      blue_rises_o <= 0;
      hist_o <= 8'h00;
    end else begin
      prev <= {pa_green_i, pa_red_i, pa_blue_i};
      if (pa_red_i && !prev[1]) begin
        red_rises_o <= red_rises_o + 1;
      end
      if (pa_blue_i && !prev[0]) begin
        blue_rises_o <= blue_rises_o + 1;
      end
      // only colour changes matter: a steady colour is one step
      if ({pa_green_i, pa_red_i} != prev[2:1]) begin
        hist_o <= {hist_o[5:0], pa_green_i, pa_red_i};
      end
    end
  end
endmodule

`default_nettype wire

// *** tb/sli_status_led_bench.sv ***
/*
  Self-checking bench of the status indicator block, APB master tasks.
  Assumes the design's one-wait-state APB slave and a shortened tick.
*/
`timescale 1ns/1ps
`default_nettype none

module sli_status_led_bench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        arst_n_i, psel, penable, pwrite, info_i, cfg_corrupt_i, link_up_i, b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_o, rd;
  logic        pready_o, pslverr_o, err;
  logic [5:0]  evt;
  logic [3:0]  alarm_code_i;
  logic        pa_green_o, pa_red_o, pa_blue_o, ms_green_o, ms_red_o, ns_green_o, ns_red_o, link_act_o;
  logic [7:0]  hist;
  int          failures, cmp_count, red_rises, blue_rises, red0, blu0;

  always #2.5 clk_i = ~clk_i;

  // short tick keeps a one-second pulse at 400 clocks
  sli_status_led #(.TICK_CYC(4)) dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .alarm_i(evt[4]), .alarm_code_i(alarm_code_i), .info_i(info_i), .cfg_corrupt_i(cfg_corrupt_i),
    .internal_err_i(evt[5]), .tcp_conn_evt_i(evt[2]), .frame_ok_i(evt[0]), .frame_err_i(evt[1]),
    .link_up_i(link_up_i), .eth_traffic_i(evt[3]), .pa_green_o(pa_green_o), .pa_red_o(pa_red_o),
    .pa_blue_o(pa_blue_o), .ms_green_o(ms_green_o), .ms_red_o(ms_red_o), .ns_green_o(ns_green_o),
    .ns_red_o(ns_red_o), .link_act_o(link_act_o));

  sli_led_watch obs (.clk_i(clk_i), .arst_n_i(arst_n_i), .pa_green_i(pa_green_o), .pa_red_i(pa_red_o),
    .pa_blue_i(pa_blue_o), .red_rises_o(red_rises), .blue_rises_o(blue_rises), .hist_o(hist));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask

  // settled values, one step after the edge
  task automatic look(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic ev(input logic [5:0] m);
    @(posedge clk_i);
    evt <= m;
    @(posedge clk_i);
    evt <= 6'h00;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    // answer taken at the edge that samples pready high, before it is cleared
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    rd = prdata_o;
    err = pslverr_o;
    if (n >= 16) begin
      failures++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    failures = 0;
    cmp_count = 0;
    arst_n_i = 1'b0;
    {psel, penable, pwrite, info_i, cfg_corrupt_i, link_up_i} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    evt = 6'h00;
    alarm_code_i = 4'h0;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    look(3);
    chk("pa_green", 32'h1, pa_green_o);
    chk("ms_green", 32'h1, ms_green_o);
    chk("ns_dark", 32'h0, {ns_green_o, ns_red_o});
    chk("link_dark", 32'h0, link_act_o);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl_reset", 32'h0, rd);
    chk("ctrl_err", 32'h0, err);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped_err", 32'h1, err);
    chk("unmapped_data", 32'h0, rd);
    // network pulses: green retriggered by a connection event, red by a second error
    ev(6'h01);
    look(4);
    chk("ns_green_on", 32'h1, ns_green_o);
    look(296);
    ev(6'h04);
    look(380);
    chk("ns_green_held", 32'h1, ns_green_o);
    look(60);
    chk("ns_green_off", 32'h0, ns_green_o);
    ev(6'h03);
    look(4);
    chk("ns_red_on", 32'h1, ns_red_o);
    chk("ns_green_under_red", 32'h0, ns_green_o);
    look(296);
    ev(6'h02);
    look(380);
    chk("ns_red_held", 32'h1, ns_red_o);
    look(60);
    chk("ns_red_off", 32'h0, ns_red_o);
    // alarm codes 0 and 2, with information pending underneath
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      alarm_code_i <= 4'(2 * k);
      info_i <= 1'b1;
      red0 = red_rises;
      ev(6'h10);
      look(20);
      chk("pa_green_alarm", 32'h0, pa_green_o);
      chk("pa_blue_alarm", 32'h0, pa_blue_o);
      look(580);
      chk("red_blinks", 32'(k + 1), 32'(red_rises - red0));
      apb(1'b0, 12'h004, 32'h0);
      chk("status_alarm", {1'b1, 4'(2 * k)}, rd[4:0]);
      @(posedge clk_i);
      info_i <= 1'b0;
      apb(1'b1, 12'h000, 32'h4);
      look(4);
      chk("pa_green_back", 32'h1, pa_green_o);
      chk("pa_red_back", 32'h0, pa_red_o);
    end
    // information, then a remote session
    for (int k = 0; k < 2; k++) begin
      if (k == 0) begin
        @(posedge clk_i);
        info_i <= 1'b1;
      end else begin
        apb(1'b1, 12'h000, 32'h2);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl_remote", 32'h2, rd);
      end
      blu0 = blue_rises;
      look(300);
      chk("blue_blinks", 32'h1, 32'(blue_rises - blu0 > 1));
      chk("pa_green_busy", 32'h0, pa_green_o);
      @(posedge clk_i);
      info_i <= 1'b0;
      apb(1'b1, 12'h000, 32'h0);
      look(4);
      chk("pa_green_done", 32'h1, pa_green_o);
    end
    // simulation beats pending information
    @(posedge clk_i);
    info_i <= 1'b1;
    apb(1'b1, 12'h000, 32'h1);
    look(860);
    chk("sim_order", 32'h72, hist);
    chk("sim_blue", 32'h0, pa_blue_o);
    @(posedge clk_i);
    info_i <= 1'b0;
    apb(1'b1, 12'h000, 32'h0);
    look(4);
    chk("pa_green_sim_end", 32'h1, pa_green_o);
    // module state
    @(posedge clk_i);
    cfg_corrupt_i <= 1'b1;
    look(10);
    b = ms_red_o;
    look(64);
    chk("ms_red_blink", {31'h0, ~b}, ms_red_o);
    chk("ms_green_bad", 32'h0, ms_green_o);
    @(posedge clk_i);
    cfg_corrupt_i <= 1'b0;
    look(4);
    chk("ms_green_ok", 32'h1, ms_green_o);
    ev(6'h20);
    look(300);
    chk("ms_red_steady", 32'h1, ms_red_o);
    chk("ms_green_err", 32'h0, ms_green_o);
    apb(1'b0, 12'h004, 32'h0);
    chk("status_err", 32'h1, rd[5]);
    // link and activity
    @(posedge clk_i);
    link_up_i <= 1'b1;
    look(4);
    chk("link_idle", 32'h1, link_act_o);
    repeat (30) begin
      ev(6'h08);
      repeat (6) @(posedge clk_i);
    end
    look(1);
    b = link_act_o;
    look(16);
    chk("link_blink", {31'h0, ~b}, link_act_o);
    @(posedge clk_i);
    link_up_i <= 1'b0;
    look(4);
    chk("link_off", 32'h0, link_act_o);
    // power cycle clears the internal error
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    look(3);
    chk("ms_red_cycled", 32'h0, ms_red_o);
    chk("ms_green_cycled", 32'h1, ms_green_o);
    complete_run();
  end
endmodule

`default_nettype wire
